/* core/rx_status_ctrl.sv */
`timescale 1ns/10ps
module rx_status_ctrl
	import rx_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// Register port
	input wire logic [7:0] addr,
	input wire logic [31:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [31:0] rd_data_r,
	// Frame stream from the MAC interface layer
	input wire logic rx_frame,
	input wire logic rx_byte_vld,
	input wire logic [7:0] rx_byte,
	input wire logic rx_err,
	input wire logic rx_coll,
	input wire logic rx_crc_bad,
	input wire logic [2:0] rx_dribble,
	input wire logic rx_speed_10,
	input wire logic rx_filter_fail,
	// Events and state
	output logic receiver_halted_pulse_r,
	output logic receive_error_flag_r,
	output logic rx_on_r
);
	rx_state_t state_r;
	logic [31:0] ctrl_r;
	logic [13:0] len_r;
	logic [15:0] lt_r;
	logic mcast_r, bcast_r, late_r, mii_err_r, wdog_r, drop_r;
	logic [31:0] word_r;
	logic [1:0] lane_r;
	logic [31:0] sts_word_r;
	logic [DATA_AW:0] d_wptr_r, d_cptr_r, d_rptr_r;
	logic [STS_AW:0] s_wptr_r, s_rptr_r;
	logic [31:0] d_q, s_q;
	logic receive_enable_bit, pass_bad;
	logic take, frame_end, busy, soft_rst, d_full, s_full;
	logic d_we, s_we, d_pop, s_pop, d_under, s_under, s_over, keep;
	logic [31:0] d_wdata;
	logic [DATA_AW:0] d_rnext, d_avail;
	logic [STS_AW:0] s_rnext, s_avail;
	logic [31:0] sts_nxt;
	logic [15:0] exp_len;
	logic is_type, runt;

	assign receive_enable_bit = ctrl_r[CTRL_RX_EN];
	assign pass_bad = ctrl_r[CTRL_PASS_BAD];
	assign take = state_r == ST_RECV && rx_frame && rx_byte_vld;
	assign frame_end = state_r == ST_RECV && !rx_frame;
	assign busy = state_r == ST_RECV || state_r == ST_DONE;
	assign soft_rst = wr_en && addr == ADDR_SOFT_RST && wr_data[SRST_BIT];
	assign d_avail = d_cptr_r - d_rptr_r;
	assign s_avail = s_wptr_r - s_rptr_r;
	assign d_full = (d_wptr_r - d_rptr_r) == DATA_DEPTH;
	assign s_full = s_avail == STS_DEPTH;

	// Control register.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_r <= CTRL_RESET;
		end else if (wr_en && addr == ADDR_CTRL) begin
			ctrl_r <= wr_data;
		end
	end

	// Receiver on/off and the halted pulse.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_on_r <= 1'b0;
			receiver_halted_pulse_r <= 1'b0;
		end else begin
			receiver_halted_pulse_r <= 1'b0;
			if (!busy) begin
				rx_on_r <= receive_enable_bit;
				if (rx_on_r && !receive_enable_bit) begin
					receiver_halted_pulse_r <= 1'b1;
				end
			end
		end
	end

	// Frame sequencing; a frame in progress always runs to its end.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_r <= ST_IDLE;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (rx_frame) begin
						// A frame that starts as the enable falls is skipped, so the halt holds.
						state_r <= (rx_on_r && receive_enable_bit) ? ST_RECV : ST_SKIP;
					end
				end
				ST_RECV: begin
					if (!rx_frame) begin
						state_r <= ST_DONE;
					end
				end
				ST_DONE: begin
					state_r <= ST_IDLE;
				end
				default: begin
					if (!rx_frame) begin
						state_r <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// Byte count and header capture.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			len_r <= '0;
			lt_r <= '0;
			mcast_r <= 1'b0;
			bcast_r <= 1'b0;
			late_r <= 1'b0;
			mii_err_r <= 1'b0;
			wdog_r <= 1'b0;
		end else if (state_r == ST_IDLE) begin
			len_r <= '0;
			lt_r <= '0;
			mcast_r <= 1'b0;
			bcast_r <= 1'b1;
			late_r <= 1'b0;
			mii_err_r <= 1'b0;
			wdog_r <= 1'b0;
		end else if (state_r == ST_RECV && rx_frame) begin
			if (rx_err) begin
				mii_err_r <= 1'b1;
			end
			if (rx_coll && len_r >= RUNT_MIN) begin
				late_r <= 1'b1;
			end
			if (rx_byte_vld) begin
				if (len_r != LEN_MAX_CNT) begin
					len_r <= len_r + 14'h0001;
				end
				if (len_r >= WDOG_LEN) begin
					wdog_r <= 1'b1;
				end
				if (len_r == '0) begin
					mcast_r <= rx_byte[0];
				end
				if (len_r < DST_LEN && rx_byte != 8'hff) begin
					bcast_r <= 1'b0;
				end
				if (len_r == LT_HI_POS) begin
					lt_r[15:8] <= rx_byte;
				end
				if (len_r == LT_LO_POS) begin
					lt_r[7:0] <= rx_byte;
				end
			end
		end
	end

	// Status word assembly at the end of the frame.
	always_comb begin
		runt = len_r < RUNT_MIN;
		is_type = len_r >= HDR_LEN && lt_r > LT_MAX;
		exp_len = lt_r < MIN_PAYLOAD ? {2'b00, RUNT_MIN} : lt_r + FRAME_OVERHEAD;
		sts_nxt = '0;
		sts_nxt[SB_FILT] = rx_filter_fail;
		sts_nxt[SB_LEN_LO +: 14] = len_r;
		sts_nxt[SB_BCAST] = bcast_r && len_r >= DST_LEN;
		sts_nxt[SB_MCAST] = mcast_r && !(bcast_r && len_r >= DST_LEN);
		sts_nxt[SB_LE] = !is_type && len_r >= HDR_LEN && {2'b00, len_r} != exp_len;
		sts_nxt[SB_RUNT] = runt;
		sts_nxt[SB_LONG] = len_r > MAX_LEN;
		sts_nxt[SB_LATE] = late_r;
		sts_nxt[SB_TYPE] = is_type;
		sts_nxt[SB_WDOG] = wdog_r;
		sts_nxt[SB_MII] = mii_err_r;
		sts_nxt[SB_DRIB] = !late_r &&
			(rx_speed_10 ? rx_dribble >= DRIB_10 : rx_dribble == DRIB_MII);
		sts_nxt[SB_CRC] = rx_crc_bad || mii_err_r;
		sts_nxt[SB_ES] = sts_nxt[SB_RUNT] | sts_nxt[SB_LONG] | sts_nxt[SB_LATE] |
			sts_nxt[SB_CRC];
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			sts_word_r <= '0;
		end else if (frame_end) begin
			sts_word_r <= sts_nxt;
		end
	end

	// Byte packing into 32-bit words, first byte in the low lane.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			word_r <= '0;
			lane_r <= '0;
		end else if (state_r == ST_IDLE || frame_end) begin
			word_r <= '0;
			lane_r <= '0;
		end else if (take) begin
			lane_r <= lane_r + 2'h1;
			if (lane_r == 2'h3) begin
				word_r <= '0;
			end else begin
				word_r[lane_r*8 +: 8] <= rx_byte;
			end
		end
	end

	// A frame that finds the data FIFO full is dropped whole.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			drop_r <= 1'b0;
		end else if (state_r == ST_IDLE) begin
			drop_r <= 1'b0;
		end else if (soft_rst || (d_we && d_full)) begin
			drop_r <= 1'b1;
		end
	end

	always_comb begin
		d_we = (take && lane_r == 2'h3) || (frame_end && lane_r != 2'h0);
		d_wdata = take ? {rx_byte, word_r[23:0]} : word_r;
		keep = !drop_r && !(sts_word_r[SB_RUNT] && !pass_bad);
		s_we = state_r == ST_DONE && keep && !s_full;
		s_over = state_r == ST_DONE && keep && s_full;
		d_pop = rd_en && addr == ADDR_DATA_PORT && d_avail != '0;
		s_pop = rd_en && addr == ADDR_STS_PORT && s_avail != '0;
		d_under = rd_en && addr == ADDR_DATA_PORT && d_avail == '0;
		s_under = rd_en && addr == ADDR_STS_PORT && s_avail == '0;
		d_rnext = d_rptr_r + {{DATA_AW{1'b0}}, d_pop};
		s_rnext = s_rptr_r + {{STS_AW{1'b0}}, s_pop};
	end

	// FIFO pointers; data is committed only together with its status word.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			d_wptr_r <= '0;
			d_cptr_r <= '0;
			d_rptr_r <= '0;
			s_wptr_r <= '0;
			s_rptr_r <= '0;
		end else if (soft_rst) begin
			d_wptr_r <= '0;
			d_cptr_r <= '0;
			d_rptr_r <= '0;
			s_wptr_r <= '0;
			s_rptr_r <= '0;
		end else begin
			d_rptr_r <= d_rnext;
			s_rptr_r <= s_rnext;
			if (d_we && !d_full && !drop_r) begin
				d_wptr_r <= d_wptr_r + 11'h001;
			end
			if (state_r == ST_DONE) begin
				if (s_we) begin
					s_wptr_r <= s_wptr_r + 5'h01;
					d_cptr_r <= d_wptr_r;
				end else begin
					d_wptr_r <= d_cptr_r;
				end
			end
		end
	end

	rx_mem #(
		.W(32),
		.AW(DATA_AW)
	) data_mem (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.we(d_we && !d_full && !drop_r),
		.waddr(d_wptr_r[DATA_AW-1:0]),
		.wdata(d_wdata),
		.raddr(d_rnext[DATA_AW-1:0]),
		.q_r(d_q)
	);

	rx_mem #(
		.W(32),
		.AW(STS_AW)
	) sts_mem (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.we(s_we),
		.waddr(s_wptr_r[STS_AW-1:0]),
		.wdata(sts_word_r),
		.raddr(s_rnext[STS_AW-1:0]),
		.q_r(s_q)
	);

	// Error flag: write one to clear, a new event in the same cycle wins.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			receive_error_flag_r <= 1'b0;
		end else if (d_under || s_under || s_over) begin
			receive_error_flag_r <= 1'b1;
		end else if ((wr_en && addr == ADDR_STAT && wr_data[STAT_ERR]) || soft_rst) begin
			receive_error_flag_r <= 1'b0;
		end
	end

	// Read data, valid in the cycle after the read strobe.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_data_r <= '0;
		end else if (rd_en) begin
			if (addr == ADDR_CTRL) begin
				rd_data_r <= ctrl_r;
			end else if (addr == ADDR_STAT) begin
				rd_data_r <= {30'h0, rx_on_r, receive_error_flag_r};
			end else if (addr == ADDR_INFO) begin
				rd_data_r <= {11'h0, s_avail, 5'h0, d_avail};
			end else if (addr == ADDR_STS_PORT) begin
				rd_data_r <= s_pop ? s_q : 32'h0000_0000;
			end else if (addr == ADDR_DATA_PORT) begin
				rd_data_r <= d_pop ? d_q : 32'h0000_0000;
			end else begin
				rd_data_r <= 32'h0000_0000;
			end
		end
	end
endmodule : rx_status_ctrl

/* core/rx_pkg.sv */
// Notes on behaviour
// - Status bits 31, 14, 9:8 and 0 always read as zero.
// - Bit 30 set when the frame failed the destination address filter.
// - Bits 29:16 hold the received frame byte count.
// - Bit 15 is the OR of bits 11, 7, 6 and 1.
// - Bit 13 set when the destination is the broadcast address.
// - Bit 12 set when actual length disagrees with the length/type field.
// - Bit 11 set when the frame ends before 64 bytes.
// - Runt frames are kept only while pass-bad-frames (control bit 16) is set.
// - Bit 10 set when the destination is a multicast address other than broadcast.
// - Bit 7 set above 1518 bytes; the frame is still received whole.
// - Bit 6 set on a collision after the 64-byte collision window.
// - Bit 5 set when length/type exceeds 1500; never for frames under 14 bytes.
// - Bit 4 set when the receive watchdog expires on over-long frames.
// - Bit 3 set when the receive error input was seen during the frame.
// - Bit 2 on 4 dribble bits (MII) or 3+ (10 Mbps), never with bit 6.
// - Bit 1 set on CRC mismatch or any receive error during the frame.
// - One halted pulse is given once the receiver has really stopped.
// - Error flag rises on host underrun of either FIFO or status overrun.
// - Receiver keeps running while the error flag is up; host clears it.
// - Frame data goes to the data FIFO first, the status word last.
package rx_pkg;
	// Register byte addresses.
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STAT = 8'h04;
	localparam logic [7:0] ADDR_INFO = 8'h08;
	localparam logic [7:0] ADDR_STS_PORT = 8'h0c;
	localparam logic [7:0] ADDR_DATA_PORT = 8'h10;
	localparam logic [7:0] ADDR_SOFT_RST = 8'h14;
	// Field positions.
	localparam int CTRL_RX_EN = 2;
	localparam int CTRL_PASS_BAD = 16;
	localparam int STAT_ERR = 0;
	localparam int STAT_ON = 1;
	localparam int SRST_BIT = 0;
	localparam int INFO_STS_LO = 16;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	// Status word layout.
	localparam int SB_FILT = 30;
	localparam int SB_LEN_LO = 16;
	localparam int SB_ES = 15;
	localparam int SB_BCAST = 13;
	localparam int SB_LE = 12;
	localparam int SB_RUNT = 11;
	localparam int SB_MCAST = 10;
	localparam int SB_LONG = 7;
	localparam int SB_LATE = 6;
	localparam int SB_TYPE = 5;
	localparam int SB_WDOG = 4;
	localparam int SB_MII = 3;
	localparam int SB_DRIB = 2;
	localparam int SB_CRC = 1;
	// Frame size limits in bytes.
	localparam logic [13:0] RUNT_MIN = 14'h0040;
	localparam logic [13:0] MAX_LEN = 14'h05ee;
	localparam logic [13:0] WDOG_LEN = 14'h0800;
	localparam logic [13:0] HDR_LEN = 14'h000e;
	localparam logic [13:0] LT_HI_POS = 14'h000c;
	localparam logic [13:0] LT_LO_POS = 14'h000d;
	localparam logic [13:0] DST_LEN = 14'h0006;
	localparam logic [13:0] LEN_MAX_CNT = 14'h3fff;
	localparam logic [15:0] LT_MAX = 16'h05dc;
	localparam logic [15:0] MIN_PAYLOAD = 16'h002e;
	localparam logic [15:0] FRAME_OVERHEAD = 16'h0012;
	localparam logic [2:0] DRIB_MII = 3'h4;
	localparam logic [2:0] DRIB_10 = 3'h3;
	// FIFO geometry.
	localparam int DATA_AW = 10;
	localparam int STS_AW = 4;
	localparam logic [DATA_AW:0] DATA_DEPTH = 11'h400;
	localparam logic [STS_AW:0] STS_DEPTH = 5'h10;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RECV = 2'b01,
		ST_DONE = 2'b10,
		ST_SKIP = 2'b11
	} rx_state_t;
endpackage : rx_pkg

/* core/rx_mem.sv */
`timescale 1ns/10ps
// Head-of-queue memory: q_r holds the word at raddr one clock later, with write bypass.
module rx_mem #(
	parameter int W = 32,
	parameter int AW = 4
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// Write side
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [W-1:0] wdata,
	// Read side
	input wire logic [AW-1:0] raddr,
	output logic [W-1:0] q_r
);
	logic [W-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge ref_clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			q_r <= '0;
		end else if (we && waddr == raddr) begin
			q_r <= wdata;
		end else begin
			q_r <= mem[raddr];
		end
	end
endmodule : rx_mem

/* verif/rx_sva.sv */
`timescale 1ns/10ps
module rx_sva
	import rx_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// Register port
	input wire logic [7:0] addr,
	input wire logic [31:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [31:0] rd_data_r,
	// Frame and events
	input wire logic rx_frame,
	input wire logic receiver_halted_pulse_r,
	input wire logic receive_error_flag_r,
	input wire logic rx_on_r
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	wire [13:0] sts_len = rd_data_r[29:16];
	sequence s_sts_rd;
		rd_en && addr == ADDR_STS_PORT;
	endsequence
	sequence s_ctrl_wr;
		wr_en && addr == ADDR_CTRL;
	endsequence
	AST_RSVD:
	assert property (s_sts_rd |=> rd_data_r[31] == 1'b0 && rd_data_r[14] == 1'b0
		&& rd_data_r[9:8] == 2'h0 && rd_data_r[0] == 1'b0) else $error("reserved bit set");
	AST_ES:
	assert property (s_sts_rd |=> rd_data_r[SB_ES] == (rd_data_r[SB_RUNT] | rd_data_r[SB_LONG]
		| rd_data_r[SB_LATE] | rd_data_r[SB_CRC])) else $error("error summary wrong");
	AST_RUNT:
	assert property (s_sts_rd |=> rd_data_r[SB_RUNT] == (sts_len != 14'h0 && sts_len < RUNT_MIN))
		else $error("runt bit wrong");
	AST_LONG:
	assert property (s_sts_rd |=> rd_data_r[SB_LONG] == (sts_len > MAX_LEN)) else $error("long bit");
	AST_WDOG:
	assert property (s_sts_rd |=> rd_data_r[SB_WDOG] == (sts_len > WDOG_LEN))
		else $error("watchdog bit wrong");
	AST_TYPE:
	assert property (s_sts_rd |=> !(sts_len < HDR_LEN && rd_data_r[SB_TYPE])) else $error("type bit");
	AST_DRIB:
	assert property (s_sts_rd |=> !(rd_data_r[SB_DRIB] && rd_data_r[SB_LATE])) else $error("dribble");
	AST_ON:
	assert property (s_ctrl_wr ##0 wr_data[CTRL_RX_EN] |-> ##[1:2] rx_on_r) else $error("not on");
	AST_HALT:
	assert property (s_ctrl_wr ##0 !wr_data[CTRL_RX_EN] && rx_on_r && !rx_frame
		|-> ##[1:3] receiver_halted_pulse_r) else $error("no halt pulse");
	AST_PULSE:
	assert property (receiver_halted_pulse_r |-> !rx_on_r ##1 !receiver_halted_pulse_r)
		else $error("halt pulse wrong");
	AST_STICKY:
	assert property ($fell(receive_error_flag_r) |-> $past(wr_en && (addr == ADDR_STAT
		&& wr_data[STAT_ERR] || addr == ADDR_SOFT_RST && wr_data[SRST_BIT])))
		else $error("error flag dropped");
endmodule : rx_sva

/* verif/mil_src.sv */
`timescale 1ns/10ps
module mil_src (
	// Clock
	input wire logic ref_clk,
	// Frame stream
	output logic rx_frame,
	output logic rx_byte_vld,
	output logic [7:0] rx_byte,
	output logic rx_err,
	output logic rx_coll,
	// End of frame report
	output logic rx_crc_bad,
	output logic [2:0] rx_dribble,
	output logic rx_speed_10,
	output logic rx_filter_fail
);
	initial begin
		{rx_frame, rx_byte_vld, rx_byte, rx_err, rx_coll} = '0;
		{rx_crc_bad, rx_dribble, rx_speed_10, rx_filter_fail} = '1;
	end
	task automatic send(input int n, input logic [7:0] d0, input logic [15:0] lt,
		input logic er, co, cr, input logic [2:0] dr, input logic s10, fi);
		logic [7:0] b;
		b = 8'h00;
		@(posedge ref_clk);
		rx_frame <= 1'b1;
		for (int i = 0; i < n; i++) begin
			b = (i == 12) ? lt[15:8] : (i == 13) ? lt[7:0] : (i == 0) ? d0 :
				(i < 6) ? {8{d0 == 8'hff}} : i[7:0];
			@(posedge ref_clk);
			rx_byte_vld <= 1'b1;
			rx_byte <= b;
			rx_err <= er && i == 20;
			rx_coll <= co && i >= 70 && i < 74;
		end
		@(posedge ref_clk);
		{rx_frame, rx_byte_vld, rx_err, rx_coll} <= '0;
		rx_byte <= ~b;
		{rx_crc_bad, rx_dribble, rx_speed_10, rx_filter_fail} <= {cr, dr, s10, fi};
		@(posedge ref_clk);
		{rx_crc_bad, rx_dribble, rx_speed_10, rx_filter_fail} <= ~{cr, dr, s10, fi};
	endtask : send
endmodule : mil_src

/* verif/testbench.sv */
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
	$display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module testbench;
	import rx_pkg::*;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wr_data = 32'h0;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [31:0] rd_data_r;
	logic rx_frame, rx_byte_vld, rx_err, rx_coll, rx_crc_bad, rx_speed_10, rx_filter_fail;
	logic [7:0] rx_byte;
	logic [2:0] rx_dribble;
	logic receiver_halted_pulse_r, receive_error_flag_r, rx_on_r;
	int bad_count = 0;
	int tests_run = 0;
	int pulses = 0;
	initial begin
		forever #10 ref_clk = ~ref_clk;
	end
	rx_status_ctrl u_dut (.ref_clk, .arst_n, .addr, .wr_data, .wr_en, .rd_en, .rd_data_r,
		.rx_frame, .rx_byte_vld, .rx_byte, .rx_err, .rx_coll, .rx_crc_bad, .rx_dribble,
		.rx_speed_10, .rx_filter_fail, .receiver_halted_pulse_r, .receive_error_flag_r,
		.rx_on_r);
	mil_src u_src (.ref_clk, .rx_frame, .rx_byte_vld, .rx_byte, .rx_err, .rx_coll,
		.rx_crc_bad, .rx_dribble, .rx_speed_10, .rx_filter_fail);
	always @(posedge ref_clk) begin
		if (receiver_halted_pulse_r === 1'b1) pulses++;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		addr <= a;
		wr_data <= v;
		wr_en <= 1'b1;
		@(posedge ref_clk);
		wr_en <= 1'b0;
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		@(posedge ref_clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge ref_clk);
		rd_en <= 1'b0;
		#1;
		`CHK(rd_data_r, e)
	endtask : rdc
	function automatic logic [31:0] exp_sts(input int n, input logic [7:0] d0,
		input logic [15:0] lt, input logic er, co, cr, input logic [2:0] dr, input logic s10, fi);
		logic [31:0] s;
		logic [15:0] m;
		s = 32'h0;
		m = (lt + 16'h0012 > 16'h0040) ? lt + 16'h0012 : 16'h0040;
		s[29:16] = n[13:0];
		s[30] = fi;
		s[13] = d0 == 8'hff;
		s[10] = d0[0] && d0 != 8'hff;
		s[12] = n >= 14 && lt <= LT_MAX && n[15:0] != m;
		s[11] = n < 64;
		s[7] = n > 1518;
		s[6] = co && n > 70;
		s[5] = n >= 14 && lt > LT_MAX;
		s[4] = n > 2048;
		s[3] = er && n > 20;
		s[2] = !s[6] && (s10 ? dr >= 3'h3 : dr == 3'h4);
		s[1] = cr || s[3];
		s[15] = s[11] | s[7] | s[6] | s[1];
		return s;
	endfunction : exp_sts
	task automatic fs(input int n, input logic [7:0] d0, input logic [15:0] lt,
		input logic er, co, cr, input logic [2:0] dr, input logic s10, fi);
		u_src.send(n, d0, lt, er, co, cr, dr, s10, fi);
		rdc(ADDR_STS_PORT, exp_sts(n, d0, lt, er, co, cr, dr, s10, fi));
		wr(ADDR_SOFT_RST, 32'h1);
	endtask : fs
	task stop_test;
		if (bad_count == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : stop_test
	initial begin
		#1ms;
		bad_count++;
		stop_test;
	end
	initial begin
		repeat (20) @(posedge ref_clk);
		arst_n <= 1'b1;
		rdc(ADDR_CTRL, CTRL_RESET);
		rdc(ADDR_STAT, 32'h0);
		rdc(8'h1c, 32'h0);
		u_src.send(64, 8'h02, 16'h002e, 0, 0, 0, 3'h0, 0, 0);
		rdc(ADDR_INFO, 32'h0);
		wr(ADDR_CTRL, 32'h0001_0004);
		rdc(ADDR_STAT, 32'h2);
		u_src.send(64, 8'h02, 16'h002e, 0, 0, 0, 3'h0, 0, 0);
		rdc(ADDR_INFO, 32'h0001_0010);
		rdc(ADDR_DATA_PORT, 32'h0000_0002);
		rdc(ADDR_DATA_PORT, 32'h0706_0000);
		rdc(ADDR_STS_PORT, 32'h0040_0000);
		wr(ADDR_SOFT_RST, 32'h1);
		fs(100, 8'hff, 16'h0800, 1, 0, 0, 3'h0, 0, 0);
		fs(60, 8'h01, 16'h0800, 0, 0, 0, 3'h0, 0, 0);
		fs(10, 8'h02, 16'h0800, 0, 0, 0, 3'h0, 0, 0);
		fs(1600, 8'h02, 16'h0800, 0, 1, 0, 3'h4, 0, 0);
		fs(80, 8'h02, 16'h0010, 0, 0, 1, 3'h3, 1, 1);
		fs(70, 8'h02, 16'h0034, 0, 0, 0, 3'h3, 0, 0);
		fs(64, 8'h02, 16'h0010, 0, 0, 0, 3'h4, 0, 0);
		fs(2100, 8'h02, 16'h0800, 0, 0, 0, 3'h0, 0, 0);
		wr(ADDR_CTRL, 32'h0000_0004);
		u_src.send(40, 8'h02, 16'h0800, 0, 0, 0, 3'h0, 0, 0);
		rdc(ADDR_INFO, 32'h0);
		rdc(ADDR_STS_PORT, 32'h0);
		rdc(ADDR_STAT, 32'h3);
		wr(ADDR_STAT, 32'h1);
		rdc(ADDR_STAT, 32'h2);
		rdc(ADDR_DATA_PORT, 32'h0);
		rdc(ADDR_STAT, 32'h3);
		fs(64, 8'h02, 16'h002e, 0, 0, 0, 3'h0, 0, 0);
		rdc(ADDR_STAT, 32'h2);
		repeat (17) u_src.send(64, 8'h02, 16'h002e, 0, 0, 0, 3'h0, 0, 0);
		rdc(ADDR_INFO, 32'h0010_0100);
		rdc(ADDR_STAT, 32'h3);
		`CHK({rx_on_r, receive_error_flag_r}, 2'h3)
		wr(ADDR_SOFT_RST, 32'h1);
		pulses = 0;
		wr(ADDR_CTRL, 32'h0);
		repeat (4) @(posedge ref_clk);
		`CHK(pulses, 1)
		`CHK(rx_on_r, 1'b0)
		rdc(ADDR_STAT, 32'h0);
		u_src.send(64, 8'h02, 16'h002e, 0, 0, 0, 3'h0, 0, 0);
		wr(ADDR_SOFT_RST, 32'h1);
		rdc(ADDR_INFO, 32'h0);
		wr(ADDR_CTRL, 32'h4);
		rdc(ADDR_STAT, 32'h2);
		`CHK({rx_on_r, receive_error_flag_r}, 2'h2)
		stop_test;
	end
endmodule : testbench
bind rx_status_ctrl rx_sva u_sva (.ref_clk, .arst_n, .addr, .wr_data, .wr_en, .rd_en,
	.rd_data_r, .rx_frame, .receiver_halted_pulse_r, .receive_error_flag_r, .rx_on_r);
